/* core/hs_i2c_controller.sv */
// High-speed I2C write controller with an AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module hs_i2c_controller #(
  parameter int QUARTER_CYCLES = 40
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  i2c_link_if.controller link
);
  localparam logic [2:0] STEP_MCODE = 3'h1;
  localparam logic [2:0] STEP_ADDR = 3'h3;
  localparam logic [2:0] STEP_CTRL = 3'h4;
  localparam logic [2:0] STEP_STOP = 3'h7;
  localparam logic [2:0] STEP_START = 3'h0;
  localparam logic [2:0] STEP_RSTART = 3'h2;
  localparam logic [2:0] STEP_HI = 3'h5;
  localparam logic [2:0] STEP_LO = 3'h6;
  localparam logic [15:0] QMAX = 16'(QUARTER_CYCLES - 1);

  // ****************************************
  // Register slave
  // ****************************************
  logic [3:0] aw_addr;
  logic aw_held, w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [9:0] target;
  logic [15:0] data;
  logic busy;
  logic [3:1] nack;
  logic do_write, go;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign go = do_write && aw_addr == hs_dac_pkg::REG_GO && w_strb[0] && w_data[0] && !busy;

  // Address and data are latched independently, so either may come first.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'h1;
      s_axi_wready <= 1'h1;
      aw_held <= 1'h0;
      w_held <= 1'h0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= hs_dac_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'h1;
        s_axi_awready <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'h1;
        s_axi_wready <= 1'h0;
      end
      if (do_write)
      begin
        aw_held <= 1'h0;
        w_held <= 1'h0;
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= (aw_addr == hs_dac_pkg::REG_STATUS || aw_addr[1:0] != 2'h0)
          ? hs_dac_pkg::RESP_DECERR : hs_dac_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'h0;
        s_axi_awready <= 1'h1;
        s_axi_wready <= 1'h1;
      end
    end
  end

  // Writable settings honour byte strobes; writes while busy still land.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      target <= 10'h000;
      data <= 16'h0000;
    end
    else if (do_write)
    begin
      if (aw_addr == hs_dac_pkg::REG_TARGET && w_strb[0])
        target[7:0] <= w_data[7:0];
      if (aw_addr == hs_dac_pkg::REG_TARGET && w_strb[1])
        target[9:8] <= w_data[9:8];
      if (aw_addr == hs_dac_pkg::REG_DATA && w_strb[0])
        data[7:0] <= w_data[7:0];
      if (aw_addr == hs_dac_pkg::REG_DATA && w_strb[1])
        data[15:8] <= w_data[15:8];
    end
  end

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'h1;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= hs_dac_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h1;
      s_axi_rresp <= hs_dac_pkg::RESP_OKAY;
      case (s_axi_araddr)
        hs_dac_pkg::REG_TARGET: s_axi_rdata <= {22'h0, target};
        hs_dac_pkg::REG_DATA: s_axi_rdata <= {16'h0, data};
        hs_dac_pkg::REG_GO: s_axi_rdata <= 32'h0;
        hs_dac_pkg::REG_STATUS: s_axi_rdata <= {28'h0, nack, busy};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= hs_dac_pkg::RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'h0;
      s_axi_arready <= 1'h1;
    end
  end

  // ****************************************
  // Link sequencer
  // ****************************************
  logic sda_meta, sda_s;
  logic [2:0] step;
  logic [3:0] bit_idx;
  logic [1:0] qtr;
  logic [15:0] qcnt;
  logic tick;
  logic [7:0] tx_byte;
  logic want_scl, want_oe;

  assign tick = busy && qcnt == QMAX;

  // The data line comes back from the far domain, so it is synchronised.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sda_meta <= 1'h1;
      sda_s <= 1'h1;
    end
    else
    begin
      sda_meta <= link.sda;
      sda_s <= sda_meta;
    end
  end

  // Byte sent at each step; the master code keeps its fixed top five bits.
  always_comb
  begin
    case (step)
      STEP_MCODE: tx_byte = {hs_dac_pkg::MCODE_FIXED, target[hs_dac_pkg::TGT_MCODE_LSB +: 3]};
      STEP_ADDR: tx_byte = {hs_dac_pkg::ADDR_FIXED, target[hs_dac_pkg::TGT_STRAP_LSB +: 2],
        hs_dac_pkg::WRITE_DIR};
      STEP_CTRL: tx_byte = {2'h0, target[hs_dac_pkg::TGT_MODE_LSB +: 2], 1'h0,
        target[hs_dac_pkg::TGT_SEL_LSB +: 2], target[hs_dac_pkg::TGT_KIND_BIT]};
      STEP_HI: tx_byte = target[hs_dac_pkg::TGT_KIND_BIT] ? {data[7:6], 6'h00} : data[7:0];
      STEP_LO: tx_byte = data[15:8];
      default: tx_byte = 8'h00;
    endcase
  end

  // Line levels per quarter: start, repeated start, bit or stop.
  always_comb
  begin
    want_scl = 1'h1;
    want_oe = 1'h0;
    if (busy)
    begin
      case (step)
        STEP_START:
        begin
          want_scl = qtr < 2'h2;
          want_oe = qtr != 2'h0;
        end
        STEP_RSTART:
        begin
          want_scl = qtr == 2'h1 || qtr == 2'h2;
          want_oe = qtr[1];
        end
        STEP_STOP:
        begin
          want_scl = qtr != 2'h0;
          want_oe = !qtr[1];
        end
        default:
        begin
          want_scl = qtr == 2'h1 || qtr == 2'h2;
          want_oe = bit_idx != hs_dac_pkg::ACK_SLOT && !tx_byte[3'h7 - bit_idx[2:0]];
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      link.scl <= 1'h1;
      link.ctl_sda_oe <= 1'h0;
    end
    else
    begin
      link.scl <= want_scl;
      link.ctl_sda_oe <= want_oe;
    end
  end

  assign link.ctl_sda_o = 1'h0;

  // Step through the frame; a missing address acknowledge jumps to stop.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      busy <= 1'h0;
      step <= 3'h0;
      bit_idx <= 4'h0;
      qtr <= 2'h0;
      qcnt <= 16'h0;
      nack <= 3'h0;
    end
    else if (go)
    begin
      busy <= 1'h1;
      step <= 3'h0;
      bit_idx <= 4'h0;
      qtr <= 2'h0;
      qcnt <= 16'h0;
      nack <= 3'h0;
    end
    else if (busy)
    begin
      qcnt <= tick ? 16'h0 : qcnt + 16'h1;
      if (tick)
        qtr <= qtr + 2'h1;
      // The master-code slot is sampled by nobody; the frame goes on regardless.
      if (tick && qtr == 2'h2 && bit_idx == hs_dac_pkg::ACK_SLOT && sda_s)
      begin
        if (step == STEP_ADDR)
          nack[hs_dac_pkg::ST_NACK_ADDR] <= 1'h1;
        if (step == STEP_CTRL)
          nack[hs_dac_pkg::ST_NACK_CTRL] <= 1'h1;
        if (step > STEP_CTRL)
          nack[hs_dac_pkg::ST_NACK_DATA] <= 1'h1;
      end
      if (tick && qtr == 2'h3)
      begin
        if (step != STEP_START && step != STEP_RSTART && step != STEP_STOP
          && bit_idx != hs_dac_pkg::ACK_SLOT)
          bit_idx <= bit_idx + 4'h1;
        else
        begin
          bit_idx <= 4'h0;
          if (step == STEP_STOP)
            busy <= 1'h0;
          else if (step == STEP_ADDR && nack[hs_dac_pkg::ST_NACK_ADDR])
            step <= STEP_STOP;
          else
            step <= step + 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* core/hs_dac_pkg.sv */
// Shared constants for the high-speed I2C DAC write link and its controller.
package hs_dac_pkg;
  // ****************************************
  // Link framing
  // ****************************************
  localparam logic [4:0] ADDR_FIXED = 5'h13;
  localparam logic [4:0] MCODE_FIXED = 5'h01;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic WRITE_DIR = 1'h0;
  localparam int CHANNELS = 4;
  // Control byte and power-down byte field positions.
  localparam int CTL_KIND_BIT = 0;
  localparam int CTL_SEL_LSB = 1;
  localparam int CTL_MODE_LSB = 4;
  localparam int PD_MODE_LSB = 6;
  // ****************************************
  // Controller registers (byte offsets)
  // ****************************************
  localparam logic [3:0] REG_TARGET = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_GO = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam int TGT_STRAP_LSB = 0;
  localparam int TGT_MCODE_LSB = 2;
  localparam int TGT_MODE_LSB = 5;
  localparam int TGT_SEL_LSB = 7;
  localparam int TGT_KIND_BIT = 9;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK_ADDR = 1;
  localparam int ST_NACK_CTRL = 2;
  localparam int ST_NACK_DATA = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

/* core/i2c_link_if.sv */
// Two-wire link between the high-speed controller and the DAC target.
`timescale 1ns/100ps
`default_nettype none
interface i2c_link_if;
  logic scl;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // Open-drain data line: any enabled driver that drives low pulls it low.
  assign sda = !((ctl_sda_oe && !ctl_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport controller (output scl, output ctl_sda_o, output ctl_sda_oe, input sda);
  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

/* core/hs_dac_target.sv */
// DAC target end of the high-speed I2C write link.
`timescale 1ns/100ps
`default_nettype none
module hs_dac_target #(
  parameter int CHANNELS = hs_dac_pkg::CHANNELS
) (
  input wire logic link_clk,
  input wire logic link_rst,
  i2c_link_if.device link,
  input wire logic addr_strap_hi,
  input wire logic addr_strap_lo,
  output logic [CHANNELS-1:0][7:0] chan_code,
  output logic [CHANNELS-1:0][1:0] chan_pd,
  output logic [1:0] update_mode,
  output logic [1:0] update_chan,
  output logic data_update
);
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_CTRL = 8'h04,
    ST_DHI = 8'h08,
    ST_DLO = 8'h10,
    ST_PHI = 8'h20,
    ST_PLO = 8'h40,
    ST_SKIP = 8'h80
  } state_e;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d;
  logic strap_hi_meta, strap_hi_s, strap_lo_meta, strap_lo_s;

  // Every pin passes two flops; the third stage only feeds edge detection.
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      scl_meta <= 1'h1;
      scl_s <= 1'h1;
      scl_d <= 1'h1;
      sda_meta <= 1'h1;
      sda_s <= 1'h1;
      sda_d <= 1'h1;
    end
    else
    begin
      scl_meta <= link.scl;
      scl_s <= scl_meta;
      scl_d <= scl_s;
      sda_meta <= link.sda;
      sda_s <= sda_meta;
      sda_d <= sda_s;
    end
  end

  // Straps are sampled continuously, so they are valid two cycles after release.
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      strap_hi_meta <= 1'h0;
      strap_hi_s <= 1'h0;
      strap_lo_meta <= 1'h0;
      strap_lo_s <= 1'h0;
    end
    else
    begin
      strap_hi_meta <= addr_strap_hi;
      strap_hi_s <= strap_hi_meta;
      strap_lo_meta <= addr_strap_lo;
      strap_lo_s <= strap_lo_meta;
    end
  end

  // ****************************************
  // Bus events
  // ****************************************
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  // A start and a repeated start look the same: data falls while clock stays high.
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;

  state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic in_ack;
  logic byte_end;
  logic want_ack;
  logic addr_hit;
  state_e next_state;
  logic ctl_kind;
  logic [1:0] ctl_sel;
  logic [7:0] code_hold;
  logic [1:0] pd_hold;

  assign byte_end = scl_fall && (bit_cnt == hs_dac_pkg::ACK_SLOT) && !in_ack;

  // Address match against fixed bits, straps and the write direction.
  assign addr_hit = (shift[7:3] == hs_dac_pkg::ADDR_FIXED)
    && (shift[2:1] == {strap_hi_s, strap_lo_s})
    && (shift[0] == hs_dac_pkg::WRITE_DIR);

  // Decide acknowledge and successor for the byte just received.
  always_comb
  begin
    want_ack = 1'h0;
    next_state = ST_SKIP;
    case (state)
      ST_ADDR:
      begin
        // The master code never matches, so it falls to skip unacknowledged.
        want_ack = addr_hit;
        next_state = addr_hit ? ST_CTRL : ST_SKIP;
      end
      ST_CTRL:
      begin
        want_ack = 1'h1;
        next_state = shift[hs_dac_pkg::CTL_KIND_BIT] ? ST_PHI : ST_DHI;
      end
      ST_DHI:
      begin
        want_ack = 1'h1;
        next_state = ST_DLO;
      end
      ST_DLO:
      begin
        want_ack = 1'h1;
        next_state = ST_DHI;
      end
      ST_PHI:
      begin
        want_ack = 1'h1;
        next_state = ST_PLO;
      end
      ST_PLO:
      begin
        want_ack = 1'h1;
        next_state = ST_SKIP;
      end
      default:
      begin
        want_ack = 1'h0;
        next_state = ST_SKIP;
      end
    endcase
  end

  // ****************************************
  // Byte engine
  // ****************************************
  // Start and stop win over any bit activity, so a pair stream ends only there.
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      in_ack <= 1'h0;
    end
    else if (start_det)
    begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      in_ack <= 1'h0;
    end
    else if (stop_det)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      in_ack <= 1'h0;
    end
    else if (scl_rise && bit_cnt != hs_dac_pkg::ACK_SLOT)
    begin
      shift <= {shift[6:0], sda_s};
      bit_cnt <= bit_cnt + 4'h1;
    end
    else if (byte_end)
    begin
      in_ack <= 1'h1;
      state <= next_state;
    end
    else if (scl_fall && in_ack)
    begin
      in_ack <= 1'h0;
      bit_cnt <= 4'h0;
    end
  end

  // Acknowledge is driven from the falling edge after bit eight to the next one.
  always_ff @(posedge link_clk)
  begin
    if (link_rst || start_det || stop_det)
      link.dev_sda_oe <= 1'h0;
    else if (byte_end)
      link.dev_sda_oe <= want_ack;
    else if (scl_fall && in_ack)
      link.dev_sda_oe <= 1'h0;
  end

  assign link.dev_sda_o = 1'h0;

  // ****************************************
  // Captured control and data
  // ****************************************
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      ctl_kind <= 1'h0;
      ctl_sel <= 2'h0;
      update_mode <= 2'h0;
      code_hold <= 8'h00;
      pd_hold <= 2'h0;
    end
    else if (byte_end)
    begin
      if (state == ST_CTRL)
      begin
        // Bits seven, six and three are fixed zero and are not checked.
        ctl_kind <= shift[hs_dac_pkg::CTL_KIND_BIT];
        ctl_sel <= shift[hs_dac_pkg::CTL_SEL_LSB +: 2];
        update_mode <= shift[hs_dac_pkg::CTL_MODE_LSB +: 2];
      end
      if (state == ST_DHI)
        code_hold <= shift;
      if (state == ST_PHI)
        pd_hold <= shift[hs_dac_pkg::PD_MODE_LSB +: 2];
    end
  end

  // Pulse once per completed data pair; data and power-down pairs both name the channel they went to.
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      data_update <= 1'h0;
      update_chan <= 2'h0;
    end
    else
    begin
      data_update <= byte_end && (state == ST_DLO);
      if (byte_end && (state == ST_DLO || state == ST_PLO))
        update_chan <= ctl_sel;
    end
  end

  // A channel changes only once its second byte is in, never on half a pair.
  for (genvar ch = 0; ch < CHANNELS; ch++)
  begin : g_chan
    always_ff @(posedge link_clk)
    begin
      if (link_rst)
      begin
        chan_code[ch] <= 8'h00;
        chan_pd[ch] <= 2'h0;
      end
      else if (byte_end && ctl_sel == 2'(ch))
      begin
        if (state == ST_DLO)
          chan_code[ch] <= code_hold;
        if (state == ST_PLO)
          chan_pd[ch] <= pd_hold;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/hs_dac_link_assertions.sv */
// Checker of the two-wire link between the controller and the DAC target.
`timescale 1ns/100ps
`default_nettype none
module hs_dac_link_assertions (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic ctl_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  // ****************
  // Bus observer
  // ****************
  logic scl_q;
  logic sda_q;
  logic idle;
  logic first_byte;
  logic [3:0] rbits;
  wire start_c = scl && scl_q && sda_q && !sda;
  wire stop_c = scl && scl_q && !sda_q && sda;
  // Tracks framing and bit position; a start always restarts the count.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      idle <= 1'b1;
      first_byte <= 1'b0;
      rbits <= 4'h0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (stop_c)
        idle <= 1'b1;
      else if (start_c)
        idle <= 1'b0;
      if (start_c)
        first_byte <= idle;
      if (start_c)
        rbits <= 4'h0;
      else if (scl && !scl_q)
        rbits <= rbits + 4'h1;
      else if (!scl && scl_q && rbits == 4'h9)
        rbits <= 4'h0;
    end
  end
  // ****************
  // Properties
  // ****************
  sequence s_ack_hold;
    dev_sda_oe [*8] ##[1:300] !dev_sda_oe;
  endsequence
  sequence s_rstart;
    ##[1:400] start_c;
  endsequence
  property p_dev_od;
    @(posedge link_clk) disable iff (link_rst) dev_sda_o == 1'b0;
  endproperty
  property p_rst_quiet;
    @(posedge link_clk) disable iff (link_rst) $fell(link_rst) |-> !dev_sda_oe;
  endproperty
  property p_oe_scl_low;
    @(posedge link_clk) disable iff (link_rst) $changed(dev_sda_oe) |-> !scl;
  endproperty
  property p_ack_slot;
    @(posedge clk_sys) disable iff (sys_rst) $rose(dev_sda_oe) |-> rbits == 4'h8;
  endproperty
  property p_ack_len;
    @(posedge clk_sys) disable iff (sys_rst) $rose(dev_sda_oe) |-> s_ack_hold;
  endproperty
  property p_mcode_nack;
    @(posedge clk_sys) disable iff (sys_rst)
      first_byte && $rose(scl) && rbits == 4'h8 |-> sda;
  endproperty
  property p_ctl_release;
    @(posedge clk_sys) disable iff (sys_rst) $rose(scl) && rbits == 4'h8 |-> !ctl_sda_oe;
  endproperty
  property p_rstart;
    @(posedge clk_sys) disable iff (sys_rst)
      first_byte && $fell(scl) && rbits == 4'h9 |-> s_rstart;
  endproperty
  property p_idle_scl;
    @(posedge clk_sys) disable iff (sys_rst) idle |-> scl;
  endproperty
  a_dev_od: assert property (p_dev_od) else $error("target drives sda high");
  a_rst_quiet: assert property (p_rst_quiet) else $error("sda pulled in reset");
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("ack moved with scl high");
  a_ack_slot: assert property (p_ack_slot) else $error("ack outside slot");
  a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
  a_mcode_nack: assert property (p_mcode_nack) else $error("master code acked");
  a_ctl_release: assert property (p_ctl_release) else $error("sda held in ack");
  a_rstart: assert property (p_rstart) else $error("no repeated start");
  a_idle_scl: assert property (p_idle_scl) else $error("scl moved while idle");
endmodule
`default_nettype wire

/* bench/test_hs_mode_i2c_dac_write.sv */
// Testbench driving the controller over AXI4-Lite against the DAC target.
`timescale 1ns/100ps
`default_nettype none
module test_hs_mode_i2c_dac_write;
  // ****************
  // Stimulus and design
  // ****************
  logic clk_sys = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic link_rst = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [1:0] strap = 2'b10;
  logic [3:0][7:0] chan_code;
  logic [3:0][1:0] chan_pd;
  logic [1:0] update_mode;
  logic [1:0] update_chan;
  logic data_update;
  logic [7:0] codes [4] = '{8'h81, 8'h7e, 8'h00, 8'hff};
  logic [31:0] rd;
  logic [1:0] resp;
  int num_errors = 0;
  int tests_run = 0;
  int pulses = 0;
  // The link clock is left free of the system clock on purpose.
  always #5 clk_sys = ~clk_sys;
  always #40 link_clk = ~link_clk;
  // Counts completed data pairs seen by the target.
  always @(posedge link_clk)
    if (data_update === 1'b1)
      pulses <= pulses + 1;
  i2c_link_if i2c_link_if_i ();
  hs_i2c_controller hs_i2c_controller_i (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .link(i2c_link_if_i.controller));
  hs_dac_target hs_dac_target_i (.link_clk, .link_rst, .link(i2c_link_if_i.device),
    .addr_strap_hi(strap[1]), .addr_strap_lo(strap[0]), .chan_code, .chan_pd,
    .update_mode, .update_chan, .data_update);
  hs_dac_link_assertions hs_dac_link_assertions_i (.clk_sys, .sys_rst, .link_clk,
    .link_rst, .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda),
    .ctl_sda_oe(i2c_link_if_i.ctl_sda_oe), .dev_sda_o(i2c_link_if_i.dev_sda_o),
    .dev_sda_oe(i2c_link_if_i.dev_sda_oe));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Address and data go out together; each valid drops on its ready, bvalid proves both.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 200);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 200)
      num_errors++;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 200);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 200)
      num_errors++;
  endtask
  function automatic logic [31:0] tw(input logic [1:0] st, input logic [1:0] md,
    input logic [1:0] ch, input logic k);
    tw = 32'h0;
    tw[hs_dac_pkg::TGT_STRAP_LSB +: 2] = st;
    tw[hs_dac_pkg::TGT_MCODE_LSB +: 3] = 3'h5;
    tw[hs_dac_pkg::TGT_MODE_LSB +: 2] = md;
    tw[hs_dac_pkg::TGT_SEL_LSB +: 2] = ch;
    tw[hs_dac_pkg::TGT_KIND_BIT] = k;
  endfunction
  // One whole frame, then the sticky status against what the frame should leave.
  task automatic frame(input logic [31:0] t, input logic [15:0] d, input logic [3:0] st);
    int n;
    n = 0;
    axi_wr(hs_dac_pkg::REG_TARGET, t);
    axi_wr(hs_dac_pkg::REG_DATA, {16'h0, d});
    axi_wr(hs_dac_pkg::REG_GO, 32'h1);
    do
    begin
      axi_rd(hs_dac_pkg::REG_STATUS);
      n++;
    end
    while (rd[hs_dac_pkg::ST_BUSY] !== 1'b0 && n < 5000);
    chk("status", rd, {28'h0, st});
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  // A hung frame or handshake is cut off well past the expected run time.
  initial
  begin
    #900000;
    num_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // The link reset belongs to the link clock, so it is released on that clock.
    @(posedge link_clk);
    link_rst <= 1'b0;
    repeat (40) @(posedge clk_sys);
    axi_rd(4'h2);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped resp", 32'(resp), 32'(hs_dac_pkg::RESP_DECERR));
    axi_wr(hs_dac_pkg::REG_STATUS, 32'hf);
    chk("status write", 32'(resp), 32'(hs_dac_pkg::RESP_DECERR));
    for (int c = 0; c < 4; c++)
    begin
      frame(tw(2'b10, c[1:0], c[1:0], 1'b0), {8'h5a, codes[c]}, 4'h0);
      chk("code", 32'(chan_code[c]), 32'(codes[c]));
      chk("mode", 32'(update_mode), c);
      chk("chan", 32'(update_chan), c);
      chk("pairs", pulses, c + 1);
    end
    frame(tw(2'b10, 2'h1, 2'h3, 1'b1), 16'h5580, 4'h0);
    chk("pd", 32'(chan_pd[3]), 32'h2);
    chk("pd other", 32'(chan_pd[2]), 32'h0);
    chk("pd keeps code", 32'(chan_code[3]), 32'hff);
    chk("pd no pair", pulses, 4);
    frame(tw(2'b01, 2'h0, 2'h0, 1'b0), 16'h0012, 4'h2);
    chk("no write", 32'(chan_code[0]), 32'h81);
    // Each frame starts over at write addressing; closing with a stop is allowed.
    frame(tw(2'b10, 2'h0, 2'h0, 1'b0), 16'h0012, 4'h0);
    chk("recovered", 32'(chan_code[0]), 32'h12);
    wrap_up();
  end
endmodule
`default_nettype wire
